// ### design/lcdi_defs.vh
// lcdi_defs.vh: constants of the character display instruction interpreter
// assumes inclusion by bare name from design files
`ifndef LCDI_DEFS_VH
`define LCDI_DEFS_VH

`define LCDI_RAM_DEPTH      80
`define LCDI_LINE_LEN       40
`define LCDI_LINE2_BASE     7'h40
`define LCDI_LINE2_LAST     7'h67
`define LCDI_LINE1_LAST     7'h27
`define LCDI_RAM_LAST       7'h4F
`define LCDI_FIFO_DEPTH     8
`define LCDI_FIFO_AW        3
`define LCDI_FIFO_W         9
`define LCDI_BLANK_CHAR     8'h20
`define LCDI_CLR_CYC        8'h50

// instruction class bit positions
`define LCDI_BIT_FSET       5
`define LCDI_BIT_DCTL       3
`define LCDI_BIT_SHIFT      4
`define LCDI_BIT_ENTRY      2
`define LCDI_BIT_HOME       1
`define LCDI_BIT_CLEAR      0
`define LCDI_BIT_DDADDR     7
`define LCDI_BIT_CGADDR     6

// function set fields
`define LCDI_FS_WIDE        4
`define LCDI_FS_TWOLINE     3
`define LCDI_FS_MODE        2

// display control fields
`define LCDI_DC_DISP        2
`define LCDI_DC_CURS        1
`define LCDI_DC_BLINK       0

// shift fields
`define LCDI_SH_DISP        3
`define LCDI_SH_RIGHT       2

// entry mode fields
`define LCDI_EM_INC         1
`define LCDI_EM_SHIFT       0

`endif

// ### design/lcdi_fifo.v
// lcdi_fifo.v: small synchronous FIFO with valid/ready on both sides
// assumes one clock, synchronous active-low reset
`timescale 1ns/1ps
`default_nettype none

module lcdi_fifo
#(
	parameter WIDTH = 9,
	parameter DEPTH = 8,
	parameter AW    = 3
)
(
	input  wire             core_clk_i,
	input  wire             reset_n_i,
	input  wire [WIDTH-1:0] in_data_i,
	input  wire             in_valid_i,
	output wire             in_ready_o,
	output wire [WIDTH-1:0] out_data_o,
	output wire             out_valid_o,
	input  wire             out_ready_i
);

reg  [WIDTH-1:0] mem_ff [0:DEPTH-1];
reg  [AW-1:0]    wr_ptr_ff;
reg  [AW-1:0]    rd_ptr_ff;
reg  [AW:0]      count_ff;
wire             do_wr;
wire             do_rd;

assign in_ready_o  = (count_ff != DEPTH);
assign out_valid_o = (count_ff != 0);
assign out_data_o  = mem_ff[rd_ptr_ff];
assign do_wr       = in_valid_i && in_ready_o;
assign do_rd       = out_valid_o && out_ready_i;

always @(posedge core_clk_i)
begin
	if (do_wr)
		mem_ff[wr_ptr_ff] <= in_data_i;
end

always @(posedge core_clk_i)
begin
	if (!reset_n_i)
	begin
		wr_ptr_ff <= {AW{1'b0}};
		rd_ptr_ff <= {AW{1'b0}};
		count_ff  <= {(AW+1){1'b0}};
	end
	else
	begin
		if (do_wr)
			wr_ptr_ff <= (wr_ptr_ff == DEPTH-1) ? {AW{1'b0}} : wr_ptr_ff + 1'b1;
		if (do_rd)
			rd_ptr_ff <= (rd_ptr_ff == DEPTH-1) ? {AW{1'b0}} : rd_ptr_ff + 1'b1;
		if (do_wr && !do_rd)
			count_ff <= count_ff + 1'b1;
		else if (do_rd && !do_wr)
			count_ff <= count_ff - 1'b1;
	end
end

endmodule

`default_nettype wire

// ### design/lcdi_core.v
// lcdi_core.v: instruction interpreter of a character display controller
// assumes a host write strobe synchronous to core_clk_i, one clock domain
//
// Summary of operation
// RULE_01: after reset the bus is full 8-bit width.
// RULE_02: in 4-bit mode two nibble accesses form one byte before execution.
// RULE_03: in 4-bit mode only upper data lines count; lower lines ignored.
// RULE_04: first function set after reset is taken as one 8-bit access.
// RULE_05: host writes function-set upper nibble twice when going to 4-bit.
// RULE_06: host issues function set before writing display content.
// RULE_07: text RAM holds 80 character codes.
// RULE_08: display shift moves the window only, never the RAM contents.
// RULE_09: return home restores the unshifted view.
// RULE_10: two-line mode wraps address from line one end to line two.
// RULE_11: host sets address itself to reach line two early.
// RULE_12: both lines shift together, no character crosses lines.
// RULE_13: serial host precedes instructions with a control byte.
// RULE_14: host initialises by instruction when power-on reset is unsure.
// RULE_15: after reset display is blank and text RAM is data target.
// RULE_16: function set selects width and two-line format from its bits.
// RULE_17: display control turns display and cursor on per its bits.
// RULE_18: increment entry mode steps address by one, no shift.
// RULE_19: return home puts window and cursor back at address zero.
// RULE_20: shift instruction moves cursor, or cursor and display, by one.
// RULE_21: in 4-bit mode upper nibble comes first, then lower nibble.
`timescale 1ns/1ps
`default_nettype none
`include "lcdi_defs.vh"

module lcdi_core
(
	input  wire       core_clk_i,
	input  wire       reset_n_i,
	input  wire       wr_strobe_i,
	input  wire       register_select_i,
	input  wire [3:0] upper_data_lines_i,
	input  wire [3:0] lower_data_lines_i,
	output wire       wr_ready_o,
	input  wire [6:0] rd_addr_i,
	output reg  [7:0] rd_char_o,
	output reg        busy_o,
	output reg        wide_bus_o,
	output reg        two_line_o,
	output reg        disp_on_o,
	output reg        cursor_on_o,
	output reg        blink_on_o,
	output reg        inc_mode_o,
	output reg        shift_mode_o,
	output reg        glyph_target_o,
	output reg  [6:0] cursor_addr_o,
	output reg  [6:0] window_ofs_o
);

////////////////////////////////////////////////////////////////////////////////
// helpers

// next address in the text ram, wrapping line one into line two and back
function [6:0] addr_step;
	input [6:0] a;
	input       up;
	input       two;
	begin
		if (up)
		begin
			if (two && a == `LCDI_LINE1_LAST)
				addr_step = `LCDI_LINE2_BASE;
			else if (two && a == `LCDI_LINE2_LAST)
				addr_step = 7'h00;
			else if (!two && a == `LCDI_RAM_LAST)
				addr_step = 7'h00;
			else
				addr_step = a + 7'h01;
		end
		else
		begin
			if (two && a == `LCDI_LINE2_BASE)
				addr_step = `LCDI_LINE1_LAST;
			else if (two && a == 7'h00)
				addr_step = `LCDI_LINE2_LAST;
			else if (!two && a == 7'h00)
				addr_step = `LCDI_RAM_LAST;
			else
				addr_step = a - 7'h01;
		end
	end
endfunction

// linear ram index; line two maps after line one
// gap between the lines maps outside the ram so it never aliases line two
function [6:0] ram_index;
	input [6:0] a;
	begin
		if (!two_line_o)
			ram_index = a;
		else if (a >= `LCDI_LINE2_BASE)
			ram_index = a - 7'h18;
		else if (a > `LCDI_LINE1_LAST)
			ram_index = 7'h7F;
		else
			ram_index = a;
	end
endfunction

// window offset modulo one line, so both lines move as one
function [6:0] ofs_step;
	input [6:0] o;
	input       right;
	reg   [6:0] lim;
	begin
		lim = two_line_o ? `LCDI_LINE1_LAST : `LCDI_RAM_LAST;
		if (right)
			ofs_step = (o == 7'h00) ? lim : o - 7'h01;
		else
			ofs_step = (o == lim) ? 7'h00 : o + 7'h01;
	end
endfunction

////////////////////////////////////////////////////////////////////////////////
// nibble assembly and fifo

reg        wide_ff;
reg        nib_pend_ff;
reg  [3:0] nib_hi_ff;
reg        nib_rs_ff;
wire       fifo_in_valid;
wire [8:0] fifo_in_data;
wire       fifo_in_ready;
wire [8:0] fifo_out_data;
wire       fifo_out_valid;
reg        fifo_out_ready;

// full bytes go straight in; narrow mode waits for the second half
assign fifo_in_valid = wr_strobe_i && (wide_ff || nib_pend_ff);                // [RULE_02]
assign fifo_in_data  = wide_ff ? {register_select_i, upper_data_lines_i, lower_data_lines_i}
                               : {nib_rs_ff, nib_hi_ff, upper_data_lines_i};   // [RULE_21] [RULE_03]
assign wr_ready_o    = fifo_in_ready;

always @(posedge core_clk_i)
begin
	if (!reset_n_i)
	begin
		nib_pend_ff <= 1'b0;
		nib_hi_ff   <= 4'h0;
		nib_rs_ff   <= 1'b0;
	end
	else if (wr_strobe_i && !wide_ff && fifo_in_ready)
	begin
		// upper nibble first; lower lines never sampled here
		nib_pend_ff <= !nib_pend_ff;                                           // [RULE_21]
		if (!nib_pend_ff)
		begin
			nib_hi_ff <= upper_data_lines_i;
			nib_rs_ff <= register_select_i;
		end
	end
	else if (wide_ff)
		nib_pend_ff <= 1'b0;
end

lcdi_fifo
#(
	.WIDTH (`LCDI_FIFO_W),
	.DEPTH (`LCDI_FIFO_DEPTH),
	.AW    (`LCDI_FIFO_AW)
)
u_fifo
(
	.core_clk_i  (core_clk_i),
	.reset_n_i   (reset_n_i),
	.in_data_i   (fifo_in_data),
	.in_valid_i  (fifo_in_valid),
	.in_ready_o  (fifo_in_ready),
	.out_data_o  (fifo_out_data),
	.out_valid_o (fifo_out_valid),
	.out_ready_i (fifo_out_ready)
);

////////////////////////////////////////////////////////////////////////////////
// execution engine

localparam ST_IDLE  = 2'b00;
localparam ST_CLEAR = 2'b01;

reg  [7:0] text_ram [0:`LCDI_RAM_DEPTH-1];
reg  [1:0] state_ff;
reg  [1:0] nxt_state;
reg  [7:0] clr_cnt_ff;
reg  [6:0] addr_ff;
reg  [6:0] nxt_addr;
reg  [6:0] ofs_ff;
reg  [6:0] nxt_ofs;
reg        ram_we;
reg  [6:0] ram_wa;
reg  [7:0] ram_wd;
wire       rs;
wire [7:0] op;

assign rs = fifo_out_data[8];
assign op = fifo_out_data[7:0];

always @*
begin
	nxt_state      = state_ff;
	nxt_addr       = addr_ff;
	nxt_ofs        = ofs_ff;
	fifo_out_ready = 1'b0;
	ram_we         = 1'b0;
	ram_wa         = ram_index(addr_ff);
	ram_wd         = op;
	case (state_ff)
		ST_IDLE:
		begin
			if (fifo_out_valid)
			begin
				fifo_out_ready = 1'b1;
				if (rs)
				begin
					if (!glyph_target_o)
						ram_we = 1'b1;
					// increment entry steps cursor by one; shift entry drags window
					nxt_addr = addr_step(addr_ff, inc_mode_o, two_line_o);         // [RULE_18] [RULE_10]
					if (shift_mode_o)
						nxt_ofs = ofs_step(ofs_ff, !inc_mode_o);                   // [RULE_12]
				end
				else if (op[`LCDI_BIT_DDADDR])
					nxt_addr = op[6:0];
				else if (op[`LCDI_BIT_SHIFT])
				begin
					// moves cursor, and window too on a display shift; ram untouched
					nxt_addr = addr_step(addr_ff, op[`LCDI_SH_RIGHT], two_line_o); // [RULE_20]
					if (op[`LCDI_SH_DISP])
						nxt_ofs = ofs_step(ofs_ff, op[`LCDI_SH_RIGHT]);            // [RULE_08] [RULE_12]
				end
				else if (op[`LCDI_BIT_HOME])
				begin
					nxt_addr = 7'h00;                                               // [RULE_19]
					nxt_ofs  = 7'h00;                                               // [RULE_09]
				end
				else if (op[`LCDI_BIT_CLEAR])
				begin
					nxt_addr  = 7'h00;
					nxt_ofs   = 7'h00;
					nxt_state = ST_CLEAR;
				end
			end
		end
		ST_CLEAR:
		begin
			ram_we = 1'b1;
			ram_wa = clr_cnt_ff[6:0];
			ram_wd = `LCDI_BLANK_CHAR;
			if (clr_cnt_ff == `LCDI_CLR_CYC - 8'h01)
				nxt_state = ST_IDLE;
		end
		default:
			nxt_state = ST_IDLE;
	endcase
end

// no reset on the ram: clear runs as a sequence after reset instead
always @(posedge core_clk_i)
begin
	if (ram_we && ram_wa < `LCDI_RAM_DEPTH)
		text_ram[ram_wa] <= ram_wd;                                            // [RULE_07]
end

always @(posedge core_clk_i)
begin
	if (!reset_n_i)
	begin
		state_ff    <= ST_CLEAR;                                               // [RULE_15]
		clr_cnt_ff  <= 8'h00;
		addr_ff     <= 7'h00;
		ofs_ff      <= 7'h00;
		wide_ff     <= 1'b1;                                                   // [RULE_01]
		two_line_o  <= 1'b0;
		disp_on_o   <= 1'b0;                                                   // [RULE_15]
		cursor_on_o <= 1'b0;
		blink_on_o  <= 1'b0;
		inc_mode_o  <= 1'b1;
		shift_mode_o   <= 1'b0;
		glyph_target_o <= 1'b0;                                                // [RULE_15]
	end
	else
	begin
		state_ff   <= nxt_state;
		addr_ff    <= nxt_addr;
		ofs_ff     <= nxt_ofs;
		clr_cnt_ff <= (state_ff == ST_CLEAR) ? clr_cnt_ff + 8'h01 : 8'h00;
		if (state_ff == ST_IDLE && fifo_out_valid && !rs)
		begin
			if (op[`LCDI_BIT_DDADDR])
				glyph_target_o <= 1'b0;
			else if (op[`LCDI_BIT_CGADDR])
				glyph_target_o <= 1'b1;
			else if (op[`LCDI_BIT_FSET])
			begin
				// the width switch itself arrived in the old width, wide or as a nibble pair
				wide_ff     <= op[`LCDI_FS_WIDE];                              // [RULE_04] [RULE_16]
				two_line_o  <= op[`LCDI_FS_TWOLINE];                           // [RULE_16]
			end
			else if (op[`LCDI_BIT_DCTL])
			begin
				disp_on_o   <= op[`LCDI_DC_DISP];                              // [RULE_17]
				cursor_on_o <= op[`LCDI_DC_CURS];                              // [RULE_17]
				blink_on_o  <= op[`LCDI_DC_BLINK];
			end
			else if (op[`LCDI_BIT_ENTRY])
			begin
				inc_mode_o   <= op[`LCDI_EM_INC];                              // [RULE_18]
				shift_mode_o <= op[`LCDI_EM_SHIFT];
			end
			else if (op[`LCDI_BIT_HOME] || op[`LCDI_BIT_CLEAR])
				glyph_target_o <= 1'b0;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// registered status outputs

always @(posedge core_clk_i)
begin
	if (!reset_n_i)
	begin
		rd_char_o     <= 8'h00;
		busy_o        <= 1'b1;
		wide_bus_o    <= 1'b1;
		cursor_addr_o <= 7'h00;
		window_ofs_o  <= 7'h00;
	end
	else
	begin
		rd_char_o     <= (ram_index(rd_addr_i) < `LCDI_RAM_DEPTH)
		                 ? text_ram[ram_index(rd_addr_i)] : 8'h00;
		busy_o        <= (state_ff != ST_IDLE) || fifo_out_valid;
		wide_bus_o    <= wide_ff;
		cursor_addr_o <= addr_ff;
		window_ofs_o  <= ofs_ff;
	end
end

endmodule

`default_nettype wire

// ### verification/lcdi_core_checker.sv
// lcdi_core_checker.sv: port-level assertions for lcdi_core
// assumes one clock, sync active-low reset, bound onto the core
`timescale 1ns/1ps
`default_nettype none
module lcdi_core_checker
(
	input wire logic       core_clk_i,
	input wire logic       reset_n_i,
	input wire logic       wr_strobe_i,
	input wire logic       wr_ready_o,
	input wire logic [6:0] rd_addr_i,
	input wire logic [7:0] rd_char_o,
	input wire logic       busy_o,
	input wire logic       wide_bus_o,
	input wire logic       disp_on_o,
	input wire logic       glyph_target_o,
	input wire logic       inc_mode_o,
	input wire logic [6:0] cursor_addr_o,
	input wire logic [6:0] window_ofs_o
);
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!reset_n_i);
	sequence s_up;
		$rose(reset_n_i);
	endsequence
	// six quiet cycles leave room for the queue-to-status latency
	sequence s_quiet;
		(!wr_strobe_i)[*6] ##0 !busy_o;
	endsequence
	////////////////////////////////////////
	reset_defaults_a: assert property (s_up |-> wide_bus_o && !disp_on_o && inc_mode_o)
		else $error("state after reset wrong");
	reset_target_a: assert property (s_up |-> !glyph_target_o && cursor_addr_o == 7'h00)
		else $error("target or address after reset wrong");
	clear_busy_a: assert property (s_up |-> busy_o [*8])
		else $error("busy dropped during blanking");
	idle_ready_a: assert property (!busy_o |-> wr_ready_o)
		else $error("queue refuses while idle");
	ofs_range_a: assert property (window_ofs_o <= 7'h4F)
		else $error("window offset beyond ram");
	ofs_step_a: assert property ($changed(window_ofs_o) |-> window_ofs_o == 7'h00
		|| window_ofs_o == $past(window_ofs_o) + 7'h01 || window_ofs_o + 7'h01 == $past(window_ofs_o)
		|| window_ofs_o == 7'h27 || window_ofs_o == 7'h4F) else $error("window moved more than one");
	quiet_stable_a: assert property (s_quiet |=> $stable(cursor_addr_o) && $stable(window_ofs_o))
		else $error("state moved without a command");
	rd_range_a: assert property (rd_addr_i >= 7'h68 |=> rd_char_o == 8'h00)
		else $error("read beyond ram not zero");
endmodule
bind lcdi_core lcdi_core_checker lcdi_core_checker_inst (.core_clk_i(core_clk_i),
	.reset_n_i(reset_n_i), .wr_strobe_i(wr_strobe_i), .wr_ready_o(wr_ready_o),
	.rd_addr_i(rd_addr_i), .rd_char_o(rd_char_o), .busy_o(busy_o), .wide_bus_o(wide_bus_o),
	.disp_on_o(disp_on_o), .glyph_target_o(glyph_target_o), .inc_mode_o(inc_mode_o),
	.cursor_addr_o(cursor_addr_o), .window_ofs_o(window_ofs_o));
`default_nettype wire

// ### verification/lcdi_host_model.sv
// lcdi_host_model.sv: host controller on the parallel write port
// assumes the device clock; a request waits for ready sampled at a falling edge
`timescale 1ns/1ps
`default_nettype none
module lcdi_host_model
(
	input  wire logic       clk_i,
	input  wire logic       ready_i,
	output var  logic       strobe_o = 1'b0,
	output var  logic       rs_o     = 1'b0,
	output var  logic [3:0] hi_o     = 4'h0,
	output var  logic [3:0] lo_o     = 4'hF,
	output var  logic       stuck_o  = 1'b0
);
	////////////////////////////////////////
	task automatic put(input logic rs, input logic [3:0] h, input logic [3:0] l);
		int   n;
		logic ok;
		begin
			n = 0;
			@(posedge clk_i);
			strobe_o <= 1'b1;
			rs_o <= rs;
			hi_o <= h;
			lo_o <= l;
			do
			begin
				@(negedge clk_i);
				ok = ready_i;
				@(posedge clk_i);
				n++;
			end
			while (ok !== 1'b1 && n < 200);
			stuck_o <= (ok !== 1'b1);
			strobe_o <= 1'b0;
			// released lines flip so stale data is never read as fresh
			hi_o <= ~h;
			lo_o <= ~l;
			rs_o <= ~rs;
		end
	endtask
	// parallel host: register select rides each access, no control byte
	task automatic wr8(input logic rs, input logic [7:0] b);
		put(rs, b[7:4], b[3:0]);
	endtask
	task automatic wr4(input logic rs, input logic [7:0] b);
		put(rs, b[7:4], ~b[3:0]);
		put(rs, b[3:0], 4'h5);
	endtask
endmodule
`default_nettype wire

// ### verification/tb_top.sv
// tb_top.sv: self-checking bench for lcdi_core with a host model
// assumes 200 MHz clock and sync active-low reset
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
	$display("BAD %s exp %0h got %0h", nm, e, g); end end
module tb_top;
	logic       core_clk_i = 1'b0;
	logic       reset_n_i  = 1'b0;
	logic [6:0] rd_addr_i  = 7'h00;
	int         num_errors = 0;
	int         n_compared = 0;
	wire logic       stb, rs, stuck, rdy, busy, wide, two, disp, curs, inc, shm, glyph, blink;
	wire logic [3:0] hi, lo;
	wire logic [7:0] rd_char;
	wire logic [6:0] caddr, wofs;
	lcdi_core lcdi_core_inst (.core_clk_i(core_clk_i), .reset_n_i(reset_n_i),
		.wr_strobe_i(stb), .register_select_i(rs), .upper_data_lines_i(hi),
		.lower_data_lines_i(lo), .wr_ready_o(rdy), .rd_addr_i(rd_addr_i), .rd_char_o(rd_char),
		.busy_o(busy), .wide_bus_o(wide), .two_line_o(two), .disp_on_o(disp),
		.cursor_on_o(curs), .blink_on_o(blink), .inc_mode_o(inc), .shift_mode_o(shm),
		.glyph_target_o(glyph), .cursor_addr_o(caddr), .window_ofs_o(wofs));
	lcdi_host_model lcdi_host_model_inst (.clk_i(core_clk_i), .ready_i(rdy), .strobe_o(stb),
		.rs_o(rs), .hi_o(hi), .lo_o(lo), .stuck_o(stuck));
	////////////////////////////////////////
	initial forever #2.5 core_clk_i = ~core_clk_i;
	task automatic finish_test();
		$display("compared %0d mismatches %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	always @(posedge core_clk_i)
		if (stuck === 1'b1)
		begin
			num_errors++;
			finish_test();
		end
	task automatic idle();
		int n;
		begin
			n = 0;
			do
			begin
				@(negedge core_clk_i);
				n++;
			end
			while (busy !== 1'b0 && n < 500);
			if (n >= 500)
			begin
				num_errors++;
				finish_test();
			end
			repeat (4) @(negedge core_clk_i);
		end
	endtask
	task automatic peek(input logic [6:0] a, input logic [7:0] e, input string nm);
		@(posedge core_clk_i);
		rd_addr_i <= a;
		@(posedge core_clk_i);
		@(negedge core_clk_i);
		`CHK(nm, e, rd_char)
	endtask
	task automatic t_reset();
		@(negedge core_clk_i);
		`CHK("busy", 1'b1, busy)
		idle();
		`CHK("wide", 1'b1, wide)
		`CHK("disp", 1'b0, disp)
		`CHK("glyph", 1'b0, glyph)
		peek(7'h00, 8'h20, "ram first");
		peek(7'h4F, 8'h20, "ram last");
		peek(7'h70, 8'h00, "ram outside");
		$display("test reset done");
	endtask
	task automatic t_narrow();
		lcdi_host_model_inst.wr8(1'b0, 8'h20);
		idle();
		`CHK("wide", 1'b0, wide)
		lcdi_host_model_inst.wr4(1'b0, 8'h28);
		lcdi_host_model_inst.wr4(1'b0, 8'h0E);
		lcdi_host_model_inst.wr4(1'b0, 8'h06);
		lcdi_host_model_inst.wr4(1'b1, 8'h50);
		idle();
		`CHK("two", 1'b1, two)
		`CHK("disp", 1'b1, disp)
		`CHK("curs", 1'b1, curs)
		`CHK("inc", 1'b1, inc)
		`CHK("shm", 1'b0, shm)
		`CHK("addr", 7'h01, caddr)
		peek(7'h00, 8'h50, "nibble pair");
		lcdi_host_model_inst.wr4(1'b0, 8'h38);
		idle();
		`CHK("wide", 1'b1, wide)
		$display("test narrow done");
	endtask
	task automatic t_wrap();
		// writes pile up behind the blanking, so the queue must refuse
		lcdi_host_model_inst.wr8(1'b0, 8'h01);
		for (int i = 0; i < 41; i++)
			lcdi_host_model_inst.wr8(1'b1, 8'h41 + i[7:0]);
		idle();
		`CHK("addr", 7'h41, caddr)
		peek(7'h27, 8'h68, "line1 end");
		peek(7'h40, 8'h69, "line2 start");
		$display("test wrap done");
	endtask
	task automatic t_shift();
		lcdi_host_model_inst.wr8(1'b0, 8'h10);
		idle();
		`CHK("addr", 7'h40, caddr)
		`CHK("ofs", 7'h00, wofs)
		lcdi_host_model_inst.wr8(1'b0, 8'h14);
		lcdi_host_model_inst.wr8(1'b0, 8'h1C);
		idle();
		// right shift steps the offset down, wrapping at the line length
		`CHK("ofs", 7'h27, wofs)
		peek(7'h40, 8'h69, "ram kept");
		lcdi_host_model_inst.wr8(1'b0, 8'h18);
		lcdi_host_model_inst.wr8(1'b0, 8'h18);
		idle();
		`CHK("ofs", 7'h01, wofs)
		lcdi_host_model_inst.wr8(1'b0, 8'h02);
		idle();
		`CHK("addr", 7'h00, caddr)
		`CHK("ofs", 7'h00, wofs)
		peek(7'h00, 8'h41, "first char");
		$display("test shift done");
	endtask
	task automatic t_modes();
		lcdi_host_model_inst.wr8(1'b0, 8'h0F);
		lcdi_host_model_inst.wr8(1'b0, 8'h07);
		lcdi_host_model_inst.wr8(1'b1, 8'h5A);
		idle();
		`CHK("blink", 1'b1, blink)
		`CHK("shm", 1'b1, shm)
		`CHK("ofs", 7'h01, wofs)
		lcdi_host_model_inst.wr8(1'b0, 8'h04);
		lcdi_host_model_inst.wr8(1'b1, 8'h5B);
		idle();
		`CHK("inc", 1'b0, inc)
		`CHK("addr", 7'h00, caddr)
		peek(7'h01, 8'h5B, "dec write");
		lcdi_host_model_inst.wr8(1'b0, 8'h06);
		lcdi_host_model_inst.wr8(1'b0, 8'h40);
		lcdi_host_model_inst.wr8(1'b1, 8'h33);
		idle();
		`CHK("glyph", 1'b1, glyph)
		`CHK("addr", 7'h01, caddr)
		peek(7'h00, 8'h5A, "text kept");
		lcdi_host_model_inst.wr8(1'b0, 8'hC0);
		idle();
		`CHK("glyph", 1'b0, glyph)
		`CHK("addr", 7'h40, caddr)
		$display("test modes done");
	endtask
	task automatic t_reinit();
		@(posedge core_clk_i);
		reset_n_i <= 1'b0;
		repeat (3) @(posedge core_clk_i);
		reset_n_i <= 1'b1;
		@(negedge core_clk_i);
		`CHK("busy", 1'b1, busy)
		`CHK("two", 1'b0, two)
		lcdi_host_model_inst.wr8(1'b0, 8'h38);
		lcdi_host_model_inst.wr8(1'b0, 8'h01);
		idle();
		`CHK("wide", 1'b1, wide)
		`CHK("two", 1'b1, two)
		`CHK("ofs", 7'h00, wofs)
		peek(7'h40, 8'h20, "ram reblank");
		$display("test reinit done");
	endtask
	initial
	begin
		repeat (3) @(posedge core_clk_i);
		reset_n_i <= 1'b1;
		t_reset();
		t_narrow();
		t_wrap();
		t_shift();
		t_modes();
		t_reinit();
		finish_test();
	end
endmodule
`default_nettype wire
